/* File: rtl/ntl_device_regs.sv */
// Device-specific register bank of the link-side port.
`timescale 1ns/1ns
`include "ntl_params.svh"
module ntl_device_regs
  import ntl_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Memory-mapped register access.
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regFromDownstream,
  output logic [31:0] regRdata,
  output logic regRvalid,
  // Error events.
  input wire logic ingressCplOverflow,
  input wire logic egressCplOverflow,
  input wire logic ingressCreditUnderrun,
  input wire logic creditProgress,
  input wire logic [3:0] stalledChan,
  input wire logic [3:0] deskewError,
  // Hardware-initialised physical status.
  input wire logic enumEnableIn,
  input wire logic muxEnableIn,
  input wire logic [2:0] portCountIn,
  // Downstream configuration request check.
  input wire logic dsCfgReq,
  input wire logic portIsZero,
  // Outputs to the rest of the switch.
  output logic errorIrq,
  output logic dsCfgUnsupported,
  output logic laneReversalAllowed,
  output logic [7:0] ftsCount,
  output logic crossMasterEn,
  output logic crossSlaveEn,
  output logic dsAccessEn
);
  logic [31:0] errStatus;
  logic [31:0] errMask;
  logic [31:0] egressCtrl;
  logic [31:0] ackLat;
  logic [31:0] phyCtrl;
  logic [31:0] phyStatus;
  logic [31:0] ingressCtrl;
  logic [31:0] next_errStatus;
  logic [31:0] errEvents;
  logic [31:0] next_rdata;
  logic wrStatus;
  logic wrIngressOk;
  ntl_timer_if tif ();
  ntl_credit_timer u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tif(tif)
  );
  assign tif.enable = egressCtrl[0];
  assign tif.longSel = egressCtrl[1];
  assign tif.progress = creditProgress;
  assign tif.stalledChan = stalledChan;
  assign wrStatus = regWrite && regAddr == `NTL_OFF_ERR_STATUS;
  // Collect hardware error events.
  always_comb begin
    errEvents = 32'h0;
    errEvents[`NTL_BIT_CPL_OVF] = ingressCplOverflow | egressCplOverflow;
    errEvents[`NTL_BIT_CREDIT_TO] = tif.timeout;
    errEvents[`NTL_BIT_UNDERRUN] = ingressCreditUnderrun;
    next_errStatus = errStatus & ~(wrStatus ? regWdata : 32'h0);
    next_errStatus = (next_errStatus | errEvents) & `NTL_ERR_BITS;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      errStatus <= 32'h0;
    end else begin
      errStatus <= next_errStatus;
    end
  end
  // Mask register, sticky, defaults to all masked.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      errMask <= `NTL_MASK_RESET;
    end else if (regWrite && regAddr == `NTL_OFF_ERR_MASK) begin
      errMask <= regWdata & `NTL_ERR_BITS;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      errorIrq <= 1'b0;
    end else begin
      errorIrq <= |(next_errStatus & ~errMask);
    end
  end
  // Egress control with captured timeout channel.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      egressCtrl <= 32'h0;
    end else begin
      if (regWrite && regAddr == `NTL_OFF_EGRESS) begin
        egressCtrl[2:0] <= regWdata[2:0];
      end
      if (tif.timeout) begin
        egressCtrl[19:16] <= tif.timeoutChan;
      end
    end
  end
  // ACK latency bits 7:0 and 23:16 are held constant; bits 15:8 take write data.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ackLat <= `NTL_ACK_RESET;
    end else if (regWrite && regAddr == `NTL_OFF_ACK_LAT) begin
      ackLat <= {8'h00, 8'hFF, regWdata[15:8], 8'h00};
    end
  end
  // Physical layer command bits.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phyCtrl <= `NTL_PHY_RESET;
    end else if (regWrite && regAddr == `NTL_OFF_PHY) begin
      phyCtrl <= regWdata & `NTL_PHY_RW_MASK;
    end
  end
  // Physical layer status with deskew flags.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phyStatus <= 32'h0;
    end else begin
      phyStatus[0] <= enumEnableIn;
      phyStatus[1] <= muxEnableIn;
      phyStatus[22:20] <= portCountIn;
      phyStatus[27:24] <= (phyStatus[27:24] & ~((regWrite && regAddr == `NTL_OFF_PHY) ? regWdata[27:24] : 4'h0))
                          | deskewError;
    end
  end
  assign wrIngressOk = regWrite && regAddr == `NTL_OFF_INGRESS && !regFromDownstream;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ingressCtrl <= 32'h0;
    end else if (wrIngressOk) begin
      ingressCtrl <= regWdata & `NTL_INGRESS_WMASK;
    end
  end
  // Outputs to datapath.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dsCfgUnsupported <= 1'b0;
      laneReversalAllowed <= 1'b0;
      ftsCount <= 8'h40;
      crossMasterEn <= 1'b0;
      crossSlaveEn <= 1'b0;
      dsAccessEn <= 1'b0;
    end else begin
      dsCfgUnsupported <= dsCfgReq && !ingressCtrl[0];
      laneReversalAllowed <= !phyCtrl[5] && !portIsZero;
      ftsCount <= phyCtrl[15:8];
      crossMasterEn <= phyCtrl[3];
      crossSlaveEn <= phyCtrl[4];
      dsAccessEn <= ingressCtrl[0];
    end
  end
  // Read mux; unmapped offsets read zero.
  always_comb begin
    case (regAddr)
      `NTL_OFF_ERR_STATUS: next_rdata = errStatus;
      `NTL_OFF_ERR_MASK: next_rdata = errMask;
      `NTL_OFF_EGRESS: next_rdata = egressCtrl;
      `NTL_OFF_ACK_LAT: next_rdata = ackLat;
      `NTL_OFF_PHY: next_rdata = phyCtrl | phyStatus;
      `NTL_OFF_INGRESS: next_rdata = ingressCtrl;
      default: next_rdata = 32'h0;
    endcase
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 32'h0;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      regRdata <= regRead ? next_rdata : 32'h0;
    end
  end
  property p_ovf_sets;
    @(posedge core_clk) disable iff (!reset_n) (ingressCplOverflow || egressCplOverflow) |=> errStatus[0];
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("Overflow did not set status.");
  property p_under_sets;
    @(posedge core_clk) disable iff (!reset_n) ingressCreditUnderrun |=> errStatus[12];
  endproperty
  a_under_sets: assert property (p_under_sets) else $error("Underrun did not set status.");
  property p_irq_masked;
    @(posedge core_clk) disable iff (!reset_n) errMask == `NTL_ERR_BITS |=> !errorIrq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("Interrupt raised while all errors masked.");
  property p_irq_follow;
    @(posedge core_clk) disable iff (!reset_n) errorIrq |-> (errStatus & ~$past(errMask)) != 32'h0;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("Interrupt without unmasked error.");
  property p_ack_const;
    @(posedge core_clk) disable iff (!reset_n) ackLat[7:0] == 8'h00 && ackLat[23:16] == 8'hFF;
  endproperty
  a_ack_const: assert property (p_ack_const) else $error("ACK latency constant fields changed.");
  property p_ds_write;
    @(posedge core_clk) disable iff (!reset_n) (regWrite && regFromDownstream) |=> $stable(ingressCtrl);
  endproperty
  a_ds_write: assert property (p_ds_write) else $error("Downstream write changed ingress control.");
  property p_ur;
    @(posedge core_clk) disable iff (!reset_n) (dsCfgReq && !ingressCtrl[0]) |=> dsCfgUnsupported;
  endproperty
  a_ur: assert property (p_ur) else $error("Unsupported Request not flagged.");
  property p_port0;
    @(posedge core_clk) disable iff (!reset_n) portIsZero |=> !laneReversalAllowed;
  endproperty
  a_port0: assert property (p_port0) else $error("Port 0 allowed lane reversal.");
endmodule : ntl_device_regs

/* File: common/ntl_params.svh */
// Register offsets, field positions, reset values and timing counts.
// Notes on behaviour
// - Completion overflow on ingress or egress FIFO sets sticky status bit 0; write one clears.
// - Missing useful credit update within selected interval sets sticky status bit 11.
// - Ingress credit underrun sets sticky status bit 12; write one clears.
// - Any error status flag can raise the interrupt when interrupt reporting is enabled.
// - Mask bits 0, 11, 12 are sticky; one masks reporting; all reset to one.
// - Egress credit timer runs only while control bit 0 is one; resets to zero.
// - Bit 1 picks timeout window 512 to 768 ms or 1024 to 1280 ms.
// - On timeout record channel and traffic type code in read-only bits 19:16.
// - ACK latency bits 7:0 stay 00h, bits 23:16 stay FFh; software keeps 15:8 zero.
// - Enumeration and multiplexing enables are hardware set bits 0 and 1, reset zero.
// - Bits 3 and 4 allow cross-link master and slave roles, reset zero.
// - Bit 5 one forbids lane reversal; port 0 never reverses lanes.
// - Advertised fast training count is bits 15:8, resetting to 40h.
// - Bits 22:20 report enumerated port count, hardware set, reset 000b.
// - Bits 24 to 27 flag deskew errors on ports 0/4, 1, 2, 3; write one clears.
// - Ingress bit 0 zero answers downstream config to switch registers with Unsupported Request.
// - Downstream access enable may be set only by upstream, link, serial bus or EEPROM.
`ifndef NTL_PARAMS_SVH
`define NTL_PARAMS_SVH
`define NTL_OFF_ERR_STATUS 12'h1CC
`define NTL_OFF_ERR_MASK 12'h1D0
`define NTL_OFF_EGRESS 12'h1E4
`define NTL_OFF_ACK_LAT 12'h1F8
`define NTL_OFF_PHY 12'h220
`define NTL_OFF_INGRESS 12'h660
`define NTL_ERR_BITS 32'h0000_1801
`define NTL_BIT_CPL_OVF 0
`define NTL_BIT_CREDIT_TO 11
`define NTL_BIT_UNDERRUN 12
`define NTL_MASK_RESET 32'h0000_1801
`define NTL_EGRESS_WMASK 32'h0000_0007
`define NTL_ACK_RESET 32'h00FF_0000
`define NTL_PHY_RW_MASK 32'h0000_FF78
`define NTL_PHY_RESET 32'h0000_4000
`define NTL_PHY_W1C_MASK 32'h0F00_0000
`define NTL_INGRESS_WMASK 32'hFFFF_FFFF
`define NTL_CLK_NS 100
`define NTL_TO_SHORT_MS 512
`define NTL_TO_LONG_MS 1024
`define NTL_TO_SHORT_CYC ((`NTL_TO_SHORT_MS * 64'd1000000) / `NTL_CLK_NS)
`define NTL_TO_LONG_CYC ((`NTL_TO_LONG_MS * 64'd1000000) / `NTL_CLK_NS)
`endif

/* File: common/ntl_pkg.sv */
// Types shared by the register bank and its credit timer.
package ntl_pkg;
  typedef enum logic [2:0] {
    NTL_ST_IDLE = 3'b001,
    NTL_ST_RUN = 3'b010,
    NTL_ST_FIRED = 3'b100
  } ntl_timer_state_t;
  typedef logic [3:0] ntl_chan_code_t;
endpackage : ntl_pkg

/* File: common/ntl_timer_if.sv */
// Signals between the register bank and the credit-update timer.
`timescale 1ns/1ns
interface ntl_timer_if;
  logic enable;
  logic longSel;
  logic progress;
  logic [3:0] stalledChan;
  logic timeout;
  logic [3:0] timeoutChan;
  modport bank (output enable, output longSel, output progress, output stalledChan, input timeout, input timeoutChan);
  modport timer (input enable, input longSel, input progress, input stalledChan, output timeout, output timeoutChan);
endinterface : ntl_timer_if

/* File: rtl/ntl_credit_timer.sv */
// Egress credit-update watchdog timer.
`timescale 1ns/1ns
`include "ntl_params.svh"
module ntl_credit_timer
  import ntl_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Bank side.
  ntl_timer_if.timer tif
);
  parameter logic [63:0] SHORT_CYC = `NTL_TO_SHORT_CYC;
  parameter logic [63:0] LONG_CYC = `NTL_TO_LONG_CYC;
  ntl_timer_state_t state;
  logic [63:0] count;
  logic [63:0] limit;
  assign limit = tif.longSel ? LONG_CYC : SHORT_CYC;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= NTL_ST_IDLE;
      count <= 64'h0;
      tif.timeout <= 1'b0;
      tif.timeoutChan <= 4'h0;
    end else begin
      tif.timeout <= 1'b0;
      case (state)
        NTL_ST_IDLE: begin
          count <= 64'h0;
          if (tif.enable) begin
            state <= NTL_ST_RUN;
          end
        end
        NTL_ST_RUN: begin
          if (!tif.enable) begin
            state <= NTL_ST_IDLE;
          end else if (tif.progress) begin
            count <= 64'h0;
          end else if (count + 64'h1 >= limit) begin
            tif.timeout <= 1'b1;
            tif.timeoutChan <= tif.stalledChan;
            state <= NTL_ST_FIRED;
          end else begin
            count <= count + 64'h1;
          end
        end
        NTL_ST_FIRED: begin
          count <= 64'h0;
          if (!tif.enable || tif.progress) begin
            state <= NTL_ST_IDLE;
          end
        end
        default: begin
          state <= NTL_ST_IDLE;
        end
      endcase
    end
  end
  property p_timer_off;
    @(posedge core_clk) disable iff (!reset_n) !tif.enable |=> !tif.timeout;
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("Timeout fired while timer disabled.");
endmodule : ntl_credit_timer

/* File: tb/ntl_host_model.sv */
// Host software model issuing memory-mapped register requests.
`timescale 1ns/1ns
module ntl_host_model (
  // Clock.
  input wire logic core_clk,
  // Register requests.
  output logic regWrite,
  output logic regRead,
  output logic [11:0] regAddr,
  output logic [31:0] regWdata,
  output logic regFromDownstream,
  // Read answer.
  input wire logic [31:0] regRdata,
  input wire logic regRvalid
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 12'h000;
    regWdata = 32'h0000_0000;
    regFromDownstream = 1'b0;
  end
  // Every access is one whole memory-mapped word request.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ds);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    regFromDownstream <= ds;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
    regFromDownstream <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic v);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(negedge core_clk);
    v = regRvalid;
    d = regRdata;
  endtask : rd
endmodule : ntl_host_model

/* File: tb/tb.sv */
// Self-checking bench for the device-specific register bank.
`timescale 1ns/1ns
module tb;
  logic core_clk, reset_n, regWrite, regRead, regFromDownstream, regRvalid;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata, rdv, rnd;
  logic iOvf, eOvf, uRun, creditProgress, enumEn, muxEn, dsCfgReq, portIsZero, vld;
  logic [3:0] stalledChan, deskewError, dsk;
  logic [2:0] portCount;
  logic errorIrq, dsCfgUnsupported, laneReversalAllowed, crossMasterEn, crossSlaveEn, dsAccessEn;
  logic [7:0] ftsCount;
  logic [31:0] mdl [int];
  logic [11:0] addrs [7] = '{12'h1CC, 12'h1D0, 12'h1E4, 12'h1F8, 12'h220, 12'h660, 12'h1D4};
  logic [31:0] evBit [3] = '{32'h1, 32'h1, 32'h1000};
  int errorCnt, nTests, cyc;

  ntl_host_model u_host (.core_clk(core_clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regFromDownstream(regFromDownstream), .regRdata(regRdata), .regRvalid(regRvalid));
  ntl_device_regs u_dut (.core_clk(core_clk), .reset_n(reset_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regFromDownstream(regFromDownstream), .regRdata(regRdata),
    .regRvalid(regRvalid), .ingressCplOverflow(iOvf), .egressCplOverflow(eOvf), .ingressCreditUnderrun(uRun),
    .creditProgress(creditProgress), .stalledChan(stalledChan), .deskewError(deskewError),
    .enumEnableIn(enumEn), .muxEnableIn(muxEn), .portCountIn(portCount), .dsCfgReq(dsCfgReq),
    .portIsZero(portIsZero), .errorIrq(errorIrq), .dsCfgUnsupported(dsCfgUnsupported),
    .laneReversalAllowed(laneReversalAllowed), .ftsCount(ftsCount), .crossMasterEn(crossMasterEn),
    .crossSlaveEn(crossSlaveEn), .dsAccessEn(dsAccessEn));

  defparam u_dut.u_timer.SHORT_CYC = 64'd20;
  defparam u_dut.u_timer.LONG_CYC = 64'd40;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errorCnt++;
      conclude();
    end
  end

  task automatic conclude();
    if (errorCnt == 0 && nTests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    nTests++;
    if (s !== e) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [31:0] rexp(input logic [11:0] a);
    if (a == 12'h220) begin
      return mdl[a] | {4'h0, dsk, 1'b0, portCount, 18'h0, muxEn, enumEn};
    end
    return mdl.exists(a) ? mdl[a] : 32'h0;
  endfunction : rexp
  task automatic rchk(input logic [11:0] a);
    u_host.rd(a, rdv, vld);
    chk("rvalid", vld, 1'b1);
    chk($sformatf("reg %h", a), rdv, rexp(a));
  endtask : rchk
  task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic ds);
    u_host.wr(a, d, ds);
    case (a)
      12'h1CC: mdl[a] = mdl[a] & ~d;
      12'h1D0: mdl[a] = d & 32'h1801;
      12'h1E4: mdl[a] = (mdl[a] & 32'hF_0000) | (d & 32'h7);
      12'h220: begin
        mdl[a] = d & 32'hFF78;
        dsk = dsk & ~d[27:24];
      end
      12'h660: if (!ds) mdl[a] = d;
      default: ;
    endcase
  endtask : wreg
  task automatic dsCheck(input logic e);
    @(posedge core_clk);
    dsCfgReq <= 1'b1;
    @(posedge core_clk);
    dsCfgReq <= 1'b0;
    @(negedge core_clk);
    chk("dsCfgUnsupported", dsCfgUnsupported, e);
  endtask : dsCheck

  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    {iOvf, eOvf, uRun, creditProgress, enumEn, muxEn, dsCfgReq, portIsZero} = 8'h00;
    creditProgress = 1'b1;
    stalledChan = 4'h0;
    deskewError = 4'h0;
    portCount = 3'h0;
    dsk = 4'h0;
    mdl = '{12'h1CC: 32'h0, 12'h1D0: 32'h1801, 12'h1E4: 32'h0, 12'h1F8: 32'h00FF_0000, 12'h220: 32'h4000,
      12'h660: 32'h0};
    void'($urandom(92283));
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (addrs[i]) rchk(addrs[i]);
    chk("ftsCount", ftsCount, 8'h40);
    chk("laneRev", laneReversalAllowed, 1'b1);
    wreg(12'h1D0, 32'hFFFF_FFFF, 1'b0);
    wreg(12'h1E4, 32'hFFFF_FFFF, 1'b0);
    wreg(12'h1F8, 32'hFFFF_00FF, 1'b0);
    wreg(12'h220, 32'hFFFF_FFBF, 1'b0);
    wreg(12'h1D4, 32'hFFFF_FFFF, 1'b0);
    foreach (addrs[i]) rchk(addrs[i]);
    chk("fts", ftsCount, 8'hFF);
    chk("xMaster", {crossMasterEn, crossSlaveEn, laneReversalAllowed}, 3'b110);
    wreg(12'h220, 32'h0000_4000, 1'b0);
    rchk(12'h220);
    chk("laneRevOn", laneReversalAllowed, 1'b1);
    portIsZero <= 1'b1;
    rchk(12'h220);
    chk("laneRevPort0", laneReversalAllowed, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      {iOvf, eOvf, uRun} <= 3'b100 >> i;
      @(posedge core_clk);
      {iOvf, eOvf, uRun} <= 3'b000;
      mdl[12'h1CC] = mdl[12'h1CC] | evBit[i];
      rchk(12'h1CC);
      chk("irqMasked", errorIrq, 1'b0);
      wreg(12'h1D0, 32'h1801 & ~evBit[i], 1'b0);
      rchk(12'h1D0);
      chk("irqOn", errorIrq, 1'b1);
      wreg(12'h1CC, evBit[i], 1'b0);
      rchk(12'h1CC);
      chk("irqOff", errorIrq, 1'b0);
      wreg(12'h1D0, 32'h1801, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      deskewError <= 4'h1 << i;
      @(posedge core_clk);
      deskewError <= 4'h0;
      dsk = dsk | (4'h1 << i);
      rchk(12'h220);
    end
    wreg(12'h220, 32'h0500_4000, 1'b0);
    rchk(12'h220);
    enumEn <= 1'b1;
    muxEn <= 1'b1;
    portCount <= 3'($urandom_range(7));
    creditProgress <= 1'b1;
    stalledChan <= 4'($urandom_range(5));
    rchk(12'h220);
    rnd = $urandom() | 32'h1;
    wreg(12'h660, rnd, 1'b1);
    rchk(12'h660);
    chk("dsAccess", dsAccessEn, 1'b0);
    dsCheck(1'b1);
    wreg(12'h660, rnd, 1'b0);
    rchk(12'h660);
    chk("dsAccessOn", dsAccessEn, 1'b1);
    dsCheck(1'b0);
    creditProgress <= 1'b0;
    wreg(12'h1E4, 32'h0000_0001, 1'b0);
    repeat (10) @(posedge core_clk);
    rchk(12'h1CC);
    repeat (15) @(posedge core_clk);
    mdl[12'h1CC] = mdl[12'h1CC] | 32'h800;
    mdl[12'h1E4] = mdl[12'h1E4] | {12'h000, stalledChan, 16'h0000};
    rchk(12'h1CC);
    rchk(12'h1E4);
    conclude();
  end
endmodule : tb
